// >>> logic/gdmp_ports.sv
// module: two 8-bit drive-mode gpio ports plus read-only auxiliary input port
`timescale 1ns/1ps
`default_nettype none
module gdmp_ports #(
  parameter int WIDTH = 8
) (
  input  wire  logic             clk,
  input  wire  logic             rst_n,
  // io instruction port
  input  wire  logic [7:0]       io_addr,
  input  wire  logic             io_write_instruction,
  input  wire  logic             io_read_instruction,
  input  wire  logic [7:0]       io_wdata,
  output logic       [7:0]       io_rdata,
  // first port pins
  input  wire  logic [WIDTH-1:0] first_port_pins_in,
  output logic       [WIDTH-1:0] first_port_pins_out,
  output logic       [WIDTH-1:0] first_port_pins_oe_n,
  output logic       [WIDTH-1:0] first_port_pullup_resistor_switch,
  output logic       [WIDTH-1:0] first_port_ttl_select,
  output logic [2*WIDTH-1:0]     first_port_sink_strength,
  // second port pins
  input  wire  logic [WIDTH-1:0] second_port_pins_in,
  output logic       [WIDTH-1:0] second_port_pins_out,
  output logic       [WIDTH-1:0] second_port_pins_oe_n,
  output logic       [WIDTH-1:0] second_port_pullup_resistor_switch,
  output logic       [WIDTH-1:0] second_port_ttl_select,
  output logic [2*WIDTH-1:0]     second_port_sink_strength,
  // auxiliary inputs, all TTL thresholds
  input  wire  logic             usb_dplus_in,
  input  wire  logic             usb_dminus_in,
  input  wire  logic             crystal_input_pin,
  input  wire  logic             regulator_pin,
  input  wire  logic             internal_clock_mode,
  input  wire  logic             ps2_mode,
  output logic                   crystal_input_pulldown_on
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [WIDTH-1:0] p0_data;
    logic [WIDTH-1:0] p1_data;
    logic [WIDTH-1:0] p0_sel_lo;
    logic [WIDTH-1:0] p0_sel_hi;
    logic [WIDTH-1:0] p1_sel_lo;
    logic [WIDTH-1:0] p1_sel_hi;
    logic [7:0]       rdata;
  } gdmp_state_t;

  gdmp_state_t state_reg;
  gdmp_state_t state_next;

  gdmp_pin_if #(.WIDTH(WIDTH)) p0_if ();
  gdmp_pin_if #(.WIDTH(WIDTH)) p1_if ();

  logic [7:0] aux_value;
  logic [7:0] p0_read;
  logic [7:0] p1_read;

  ////////////////////////////////////////////////////////////////////////////
  // decoders
  assign p0_if.data   = state_reg.p0_data;
  assign p0_if.sel_lo = state_reg.p0_sel_lo;
  assign p0_if.sel_hi = state_reg.p0_sel_hi;
  assign p1_if.data   = state_reg.p1_data;
  assign p1_if.sel_lo = state_reg.p1_sel_lo;
  assign p1_if.sel_hi = state_reg.p1_sel_hi;

  gdmp_pin_decode #(.WIDTH(WIDTH)) u_p0_dec (.pins(p0_if.dec));
  gdmp_pin_decode #(.WIDTH(WIDTH)) u_p1_dec (.pins(p1_if.dec));

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: out pin carries the driven level, oe_n low while driving
  assign first_port_pins_out  = p0_if.source_on;  // high when sourcing, low when sinking
  assign first_port_pins_oe_n = ~(p0_if.source_on | p0_if.sink_on);
  assign second_port_pins_out  = p1_if.source_on;
  assign second_port_pins_oe_n = ~(p1_if.source_on | p1_if.sink_on);
  assign first_port_pullup_resistor_switch  = p0_if.pullup_on;
  assign second_port_pullup_resistor_switch = p1_if.pullup_on;
  assign first_port_ttl_select  = p0_if.ttl_sel;
  assign second_port_ttl_select = p1_if.ttl_sel;
  assign first_port_sink_strength  = p0_if.sink_strength;
  assign second_port_sink_strength = p1_if.sink_strength;

  // crystal pin gets a weak pull-down only in internal clock mode
  assign crystal_input_pulldown_on = internal_clock_mode;

  ////////////////////////////////////////////////////////////////////////////
  // read sources; data reads return the pin levels, which equal the
  // driven value whenever the pin is driven, high with its pull-up on, and the outside level otherwise
  assign p0_read = 8'(first_port_pins_in);
  assign p1_read = 8'(second_port_pins_in);

  // auxiliary value; reserved bits stay zero
  always_comb begin
    aux_value = 8'h00;
    aux_value[gdmp_pkg::AUX_BIT_DPLUS]  = usb_dplus_in;
    aux_value[gdmp_pkg::AUX_BIT_DMINUS] = usb_dminus_in;
    // gated so the bit never toggles from the oscillator in external mode
    aux_value[gdmp_pkg::AUX_BIT_CRYSTAL]   = internal_clock_mode & crystal_input_pin;
    aux_value[gdmp_pkg::AUX_BIT_REGULATOR] = ps2_mode & regulator_pin;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state: io writes and registered read data
  always_comb begin
    state_next = state_reg;
    if (io_write_instruction) begin
      unique case (io_addr)
        gdmp_pkg::ADDR_PORT0_PIN_DATA:          state_next.p0_data   = io_wdata[WIDTH-1:0];
        gdmp_pkg::ADDR_PORT1_PIN_DATA:          state_next.p1_data   = io_wdata[WIDTH-1:0];
        gdmp_pkg::ADDR_PORT0_DRIVE_SELECT_LOW:  state_next.p0_sel_lo = io_wdata[WIDTH-1:0];
        gdmp_pkg::ADDR_PORT0_DRIVE_SELECT_HIGH: state_next.p0_sel_hi = io_wdata[WIDTH-1:0];
        gdmp_pkg::ADDR_PORT1_DRIVE_SELECT_LOW:  state_next.p1_sel_lo = io_wdata[WIDTH-1:0];
        gdmp_pkg::ADDR_PORT1_DRIVE_SELECT_HIGH: state_next.p1_sel_hi = io_wdata[WIDTH-1:0];
        // auxiliary port and unlisted addresses ignore writes
        default: ;
      endcase
    end
    if (io_read_instruction) begin
      // mode registers are write-only and read as zero
      unique case (io_addr)
        gdmp_pkg::ADDR_PORT0_PIN_DATA:  state_next.rdata = p0_read;
        gdmp_pkg::ADDR_PORT1_PIN_DATA:  state_next.rdata = p1_read;
        gdmp_pkg::ADDR_AUX_INPUT_STATE: state_next.rdata = aux_value;
        default:                        state_next.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign io_rdata = state_reg.rdata;

endmodule : gdmp_ports
`default_nettype wire

// >>> logic/gdmp_pkg.sv
// package: register map, reset values and drive-mode codes for the gpio drive-mode ports
`default_nettype none
package gdmp_pkg;
  localparam logic [7:0] ADDR_PORT0_PIN_DATA          = 8'h00;
  localparam logic [7:0] ADDR_PORT1_PIN_DATA          = 8'h01;
  localparam logic [7:0] ADDR_AUX_INPUT_STATE         = 8'h02;
  localparam logic [7:0] ADDR_PORT0_DRIVE_SELECT_LOW  = 8'h0a;
  localparam logic [7:0] ADDR_PORT0_DRIVE_SELECT_HIGH = 8'h0b;
  localparam logic [7:0] ADDR_PORT1_DRIVE_SELECT_LOW  = 8'h0c;
  localparam logic [7:0] ADDR_PORT1_DRIVE_SELECT_HIGH = 8'h0d;
  localparam logic [7:0] RESET_REG                    = 8'h00;
  // auxiliary register field positions
  localparam int AUX_BIT_DPLUS     = 5;
  localparam int AUX_BIT_DMINUS    = 4;
  localparam int AUX_BIT_CRYSTAL   = 1;
  localparam int AUX_BIT_REGULATOR = 0;
  // drive-mode encoding {drive_sel_hi, drive_sel_lo, data}
  localparam logic [2:0] MODE_LOW_SINK_CODE  = 3'h4;
  localparam logic [2:0] MODE_MED_SINK_CODE  = 3'h2;
  localparam logic [2:0] MODE_HIGH_SINK_CODE = 3'h6;
  localparam logic [2:0] MODE_RESISTIVE_CODE = 3'h5;
  localparam logic [2:0] MODE_TTL_CODE       = 3'h1;
  // sink strength code on sink_strength: 0 off, 1 = 2 mA, 2 = 8 mA, 3 = 50 mA
  localparam logic [1:0] SINK_OFF  = 2'h0;
  localparam logic [1:0] SINK_2MA  = 2'h1;
  localparam logic [1:0] SINK_8MA  = 2'h2;
  localparam logic [1:0] SINK_50MA = 2'h3;
endpackage : gdmp_pkg
`default_nettype wire

// >>> logic/gdmp_pin_if.sv
// interface: per-port drive controls between the register file and the pin decoder
`timescale 1ns/1ps
`default_nettype none
interface gdmp_pin_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic [WIDTH-1:0] sel_lo;
  logic [WIDTH-1:0] sel_hi;
  logic [WIDTH-1:0] sink_on;
  logic [WIDTH-1:0] source_on;
  logic [WIDTH-1:0] pullup_on;
  logic [WIDTH-1:0] ttl_sel;
  logic [2*WIDTH-1:0] sink_strength;
  modport ctrl (output data, output sel_lo, output sel_hi,
                input sink_on, input source_on, input pullup_on, input ttl_sel,
                input sink_strength);
  modport dec  (input data, input sel_lo, input sel_hi,
                output sink_on, output source_on, output pullup_on, output ttl_sel,
                output sink_strength);
endinterface : gdmp_pin_if
`default_nettype wire

// >>> logic/gdmp_pin_decode.sv
// module: per-pin drive-state decoder for one port
`timescale 1ns/1ps
`default_nettype none
module gdmp_pin_decode #(
  parameter int WIDTH = 8
) (
  gdmp_pin_if.dec pins
);
  ////////////////////////////////////////////////////////////////////////////
  // one decoder per pin; pure combinational, registers live upstream
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    logic [2:0] code;
    assign code = {pins.sel_hi[i], pins.sel_lo[i], pins.data[i]};
    // source only with sel_lo and data high, sel_hi is don't care
    assign pins.source_on[i] = pins.sel_lo[i] & pins.data[i];
    // sink whenever data low and any select set
    assign pins.sink_on[i]   = ~pins.data[i] & (pins.sel_lo[i] | pins.sel_hi[i]);
    assign pins.pullup_on[i] = (code == gdmp_pkg::MODE_RESISTIVE_CODE);
    assign pins.ttl_sel[i]   = (code == gdmp_pkg::MODE_TTL_CODE);
    logic [1:0] strength;
    // strength tag follows the sink selects; off whenever the pin is not sinking
    // a local per-pin value keeps one continuous driver on each slice
    always_comb begin
      unique case (code)
        gdmp_pkg::MODE_LOW_SINK_CODE:  strength = gdmp_pkg::SINK_2MA;
        gdmp_pkg::MODE_MED_SINK_CODE:  strength = gdmp_pkg::SINK_8MA;
        gdmp_pkg::MODE_HIGH_SINK_CODE: strength = gdmp_pkg::SINK_50MA;
        default:                       strength = gdmp_pkg::SINK_OFF;
      endcase
    end
    assign pins.sink_strength[2*i +: 2] = strength;
  end
endmodule : gdmp_pin_decode
`default_nettype wire

// >>> verification/gdmp_ports_sva.sv
// checker: port-level assertions for the drive-mode gpio ports
`timescale 1ns/1ps
`default_nettype none
module gdmp_ports_sva #(parameter int WIDTH = 8) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic [7:0]         io_addr,
  input wire logic               io_write_instruction,
  input wire logic               io_read_instruction,
  input wire logic [7:0]         io_wdata,
  input wire logic [7:0]         io_rdata,
  input wire logic [WIDTH-1:0]   first_port_pins_out,
  input wire logic [WIDTH-1:0]   first_port_pins_oe_n,
  input wire logic [WIDTH-1:0]   first_port_pullup_resistor_switch,
  input wire logic [WIDTH-1:0]   first_port_ttl_select,
  input wire logic [2*WIDTH-1:0] first_port_sink_strength,
  input wire logic [WIDTH-1:0]   second_port_pins_oe_n,
  input wire logic               usb_dplus_in,
  input wire logic               usb_dminus_in,
  input wire logic               crystal_input_pin,
  input wire logic               regulator_pin,
  input wire logic               internal_clock_mode,
  input wire logic               ps2_mode,
  input wire logic               crystal_input_pulldown_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  a_reset_all_float: assert property ($rose(rst_n) |->
    &first_port_pins_oe_n && &second_port_pins_oe_n) else $error("pins driven after reset");
  a_sel_lo_drives: assert property (io_write_instruction && io_addr == 8'h0a |=>
    (first_port_pins_oe_n & $past(io_wdata)) == 8'h00) else $error("port0 sel_lo not driving");
  a_second_sel_lo: assert property (io_write_instruction && io_addr == 8'h0c |=>
    (second_port_pins_oe_n & $past(io_wdata)) == 8'h00) else $error("port1 sel_lo not driving");
  a_pullup_undriven: assert property (
    (~first_port_pins_oe_n & first_port_pullup_resistor_switch) == 8'h00) else $error("pull-up on");
  a_ttl_undriven: assert property ((first_port_ttl_select & (~first_port_pins_oe_n |
    first_port_pullup_resistor_switch)) == 8'h00) else $error("ttl on a driven pin");
  a_sink_pulls_low: assert property (first_port_sink_strength[1:0] != 2'h0 |->
    !first_port_pins_oe_n[0] && !first_port_pins_out[0]) else $error("sink without low drive");
  a_aux_usb_fields: assert property (io_read_instruction && io_addr == 8'h02 |=>
    io_rdata[7:6] == 2'h0 && io_rdata[3:2] == 2'h0 &&
    io_rdata[5:4] == $past({usb_dplus_in, usb_dminus_in})) else $error("aux usb field");
  a_aux_gated_bits: assert property (io_read_instruction && io_addr == 8'h02 |=>
    io_rdata[1:0] == $past({crystal_input_pin & internal_clock_mode,
    regulator_pin & ps2_mode})) else $error("aux gated bits");
  a_mode_regs_wo: assert property (io_read_instruction && io_addr inside {[8'h0a:8'h0d]} |=>
    io_rdata == 8'h00) else $error("mode register readable");
  a_pulldown_mode: assert property (
    crystal_input_pulldown_on == internal_clock_mode) else $error("crystal pull-down");
  c_aux_read: cover property (io_read_instruction && io_addr == 8'h02);
  c_high_sink: cover property (first_port_sink_strength[1:0] == 2'h3);
  c_pullup: cover property (|first_port_pullup_resistor_switch);
endmodule : gdmp_ports_sva
bind gdmp_ports gdmp_ports_sva #(.WIDTH(WIDTH)) i_sva (.clk, .rst_n, .io_addr,
  .io_write_instruction, .io_read_instruction, .io_wdata, .io_rdata, .first_port_pins_out,
  .first_port_pins_oe_n, .first_port_pullup_resistor_switch, .first_port_ttl_select,
  .first_port_sink_strength, .second_port_pins_oe_n, .usb_dplus_in, .usb_dminus_in,
  .crystal_input_pin, .regulator_pin, .internal_clock_mode, .ps2_mode, .crystal_input_pulldown_on);
`default_nettype wire

// >>> verification/gdmp_board.sv
// partner: board circuitry resolving each pad from drivers, pull-up and outside level
`timescale 1ns/1ps
`default_nettype none
module gdmp_board #(parameter int WIDTH = 8) (
  input  wire logic [WIDTH-1:0] pins_out,
  input  wire logic [WIDTH-1:0] pins_oe_n,
  input  wire logic [WIDTH-1:0] pullup_on,
  input  wire logic [WIDTH-1:0] ext_level,
  output logic      [WIDTH-1:0] pins_in
);
  // a floating pad reads high with its pull-up on, else the outside level, never the last driven one
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      pins_in[i] = !pins_oe_n[i] ? pins_out[i] : (pullup_on[i] ? 1'b1 : ext_level[i]);
    end
  end
endmodule : gdmp_board
`default_nettype wire

// >>> verification/tb_top.sv
// testbench: random drive modes on both ports, auxiliary reads, refused accesses
`timescale 1ns/1ps
`default_nettype none
`define GDMP_CHECK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
  typedef struct {logic [7:0] rd; logic [47:0] pv; logic [1:0] sel;} gdmp_note_t;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, xp;
  logic [5:0] aux = 6'h00;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, lo, hi, drv;
  logic [7:0] o [2], oe [2], pu [2], ttl [2], pin [2], ext [2] = '{8'h00, 8'h00};
  logic [15:0] ss [2], sx;
  logic [31:0] seed = 32'h226482e9;
  int n_fail = 0, check_count = 0;
  gdmp_note_t q [$], nt;
  always #50 clk = ~clk;
  gdmp_ports i_dut (.clk(clk), .rst_n(rst_n), .io_addr(addr), .io_write_instruction(wr),
    .io_read_instruction(rd), .io_wdata(wdata), .io_rdata(rdata), .first_port_pins_in(pin[0]),
    .first_port_pins_out(o[0]), .first_port_pins_oe_n(oe[0]),
    .first_port_pullup_resistor_switch(pu[0]), .first_port_ttl_select(ttl[0]),
    .first_port_sink_strength(ss[0]), .second_port_pins_in(pin[1]), .second_port_pins_out(o[1]),
    .second_port_pins_oe_n(oe[1]), .second_port_pullup_resistor_switch(pu[1]),
    .second_port_ttl_select(ttl[1]), .second_port_sink_strength(ss[1]), .usb_dplus_in(aux[5]),
    .usb_dminus_in(aux[4]), .crystal_input_pin(aux[3]), .regulator_pin(aux[2]),
    .internal_clock_mode(aux[1]), .ps2_mode(aux[0]), .crystal_input_pulldown_on());
  for (genvar p = 0; p < 2; p++) begin : g_board
    gdmp_board i_board (.pins_out(o[p]), .pins_oe_n(oe[p]), .pullup_on(pu[p]),
      .ext_level(ext[p]), .pins_in(pin[p]));
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // one strobe cycle; a spare cycle keeps strobes from being reassigned in one step
  task automatic io_op(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= w; rd <= ~w;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b0;
  endtask : io_op
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  // monitor: each read result is matched with the oldest note
  always @(posedge clk) rd_d <= rd & rst_n;
  always @(negedge clk) if (rd_d) begin
    nt = q.pop_front();
    `GDMP_CHECK("rdata", nt.rd, rdata)
    xp = nt.sel[1];
    if (nt.sel != 2'h0) `GDMP_CHECK("pins", nt.pv, {oe[xp], o[xp] & ~oe[xp], pu[xp], ttl[xp], ss[xp]})
  end
  initial begin
    d = 8'h00; lo = 8'h00; hi = 8'h00;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 24; k++) begin
      for (int p = 0; p < 2; p++) begin
        if (k > 0) begin
          {d, lo, hi} = 24'(rnd());
          if (k == 1) {d, hi} = 16'h0000;
          io_op(1'b1, 8'(p), d);
          io_op(1'b1, 8'(8'h0a + 2 * p), lo);
          io_op(1'b1, 8'(8'h0b + 2 * p), hi);
        end
        ext[p] <= 8'(rnd());
        @(posedge clk);
        drv = lo | (hi & ~d);
        for (int i = 0; i < 8; i++) sx[2*i+:2] = d[i] ? 2'h0 : {lo[i], hi[i]};
        q.push_back('{(d & drv) | (~drv & ((hi & d) | ext[p])),
          {~drv, d & lo, hi & ~lo & d, d & ~lo & ~hi, sx}, 2'(1 + p)});
        io_op(1'b0, 8'(p), 8'h00);
      end
      aux <= 6'(rnd());
      io_op(1'b1, 8'h02, 8'hff);
      q.push_back('{{2'h0, aux[5:4], 2'h0, aux[3] & aux[1], aux[2] & aux[0]}, 48'h0, 2'h0});
      io_op(1'b0, 8'h02, 8'h00);
      q.push_back('{8'h00, 48'h0, 2'h0});
      io_op(1'b0, (k % 2) ? 8'h03 : 8'(8'h0a + k % 4), 8'h00);
    end
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
